//--- design/p2pfs_pin_cell.sv
`timescale 1ns/10ps
module p2pfs_pin_cell
  import p2pfs_pkg::*;
#(
  parameter logic DRIVE01 = 1'b0,
  parameter logic DRIVE11 = 1'b0
) (
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic [1:0] code_in,
  input  wire logic       latch_in,
  input  wire logic       alt_in,
  output logic            pin_out_out,
  output logic            pin_oe_out
);

  typedef struct packed {
    logic out;
    logic oe;
  } p2pfs_cell_t;

  p2pfs_cell_t cell_q;
  p2pfs_cell_t cell_d;

  // ---------------------------------------------------------------------------
  // Driver selection
  // ---------------------------------------------------------------------------
  always_comb begin
    cell_d = '0;
    unique case (code_in)
      P2PFS_PUSH_PULL: begin
        cell_d.oe  = 1'b1;
        cell_d.out = latch_in;
      end
      P2PFS_ALT_LOW: begin
        cell_d.oe  = DRIVE01;
        cell_d.out = DRIVE01 & alt_in;
      end
      P2PFS_ALT_HIGH: begin
        cell_d.oe  = DRIVE11;
        cell_d.out = DRIVE11 & alt_in;
      end
      P2PFS_INPUT: begin
        cell_d = '0;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cell_q <= '0;
    end else begin
      cell_q <= cell_d;
    end
  end

  assign pin_out_out = cell_q.out;
  assign pin_oe_out  = cell_q.oe;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  property p_cell_input_quiet;
    @(posedge clk_in) disable iff (sys_rst_in)
      (code_in == P2PFS_INPUT) |=> !pin_oe_out && !pin_out_out;
  endproperty
  a_cell_input_quiet: assert property (p_cell_input_quiet)
    else $error("Pin drives while its field selects input.");

endmodule : p2pfs_pin_cell

//--- design/p2pfs_top.sv
// Functional notes
// - Code 10 drives pin from data latch.
// - Unused code 01 connects no peripheral.
// - Upper 5:4 codes 00/11 route receive pin to receiver.
// - Upper 3:2 code 11 drives serial clock.
// - Upper 1:0 code 11 drives serial data.
// - Lower 7:6 code 00 input feeds serial-in.
// - Lower 7:6 code 11 selects analog seven.
// - Lower 5:4 code 01 drives timer output.
// - Lower 5:4 code 11 selects analog four.
// - Lower 1:0 codes 00/01 feed timer clock.
// - Lower 1:0 code 11 drives timebase PWM.
`timescale 1ns/10ps
module p2pfs_top
  import p2pfs_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  input  wire logic [7:0] reg_wdata_in,
  output logic      [7:0] reg_rdata_out,
  input  wire logic [7:0] port_latch_in,
  input  wire logic [7:0] pin_in,
  output logic      [7:0] pin_out_out,
  output logic      [7:0] pin_oe_out,
  input  wire logic       uart_tx_in,
  input  wire logic       sck_in,
  input  wire logic       so_in,
  input  wire logic       timer_one_output_in,
  input  wire logic       timebase_pwm_out_in,
  output logic            uart_rx_out,
  output logic            si_out,
  output logic            timer_one_ext_clock_out,
  output logic            analog_channel_seven_out,
  output logic            analog_channel_four_out
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] cfg_lo;
    logic [7:0] cfg_hi;
    logic [7:0] rdata;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic       rx;
    logic       si;
    logic       t1ck;
    logic       ach7;
    logic       ach4;
  } p2pfs_state_t;

  p2pfs_state_t st_q;
  p2pfs_state_t st_d;
  logic [15:0]  cfg_all;
  logic [7:0]   alt_vec;

  assign cfg_all = {st_q.cfg_hi, st_q.cfg_lo};

  // The field picker assumes that the eight fields fill the two registers exactly.
  if (P2PFS_PINS * P2PFS_FLD_W != 16) begin : g_layout_check
    $error("Pin count and field width do not fill the two configuration registers.");
  end

  // Peripheral outputs placed on the pins whose alternate function drives.
  assign alt_vec = {uart_tx_in, 1'b0, sck_in, so_in,
                    1'b0, timer_one_output_in, 1'b0, timebase_pwm_out_in};

  // ---------------------------------------------------------------------------
  // Register access, pin synchronisers and peripheral input routing
  // ---------------------------------------------------------------------------
  always_comb begin
    st_d       = st_q;
    st_d.sync1 = pin_in;
    st_d.sync2 = st_q.sync1;
    if (reg_wr_in && (reg_addr_in == P2PFS_LOW_OFS)) begin
      st_d.cfg_lo = reg_wdata_in;
    end
    if (reg_wr_in && (reg_addr_in == P2PFS_HIGH_OFS)) begin
      st_d.cfg_hi = reg_wdata_in;
    end
    // A read returns the value held before any write in the same cycle.
    if (reg_rd_in) begin
      if (reg_addr_in == P2PFS_LOW_OFS) begin
        st_d.rdata = st_q.cfg_lo;
      end else if (reg_addr_in == P2PFS_HIGH_OFS) begin
        st_d.rdata = st_q.cfg_hi;
      end else begin
        st_d.rdata = P2PFS_RD_IDLE;
      end
    end
    // Code 11 on the receive pin keeps the receiver connected as well.
    if ((p2pfs_code_of(cfg_all, P2PFS_RX_PIN) == P2PFS_INPUT)
        || (p2pfs_code_of(cfg_all, P2PFS_RX_PIN) == P2PFS_ALT_HIGH)) begin
      st_d.rx = st_q.sync2[P2PFS_RX_PIN];
    end else begin
      st_d.rx = P2PFS_RX_IDLE;
    end
    st_d.si   = (p2pfs_code_of(cfg_all, P2PFS_SI_PIN) == P2PFS_INPUT)
                & st_q.sync2[P2PFS_SI_PIN];
    st_d.ach7 = (p2pfs_code_of(cfg_all, P2PFS_SI_PIN) == P2PFS_ALT_HIGH);
    st_d.ach4 = (p2pfs_code_of(cfg_all, P2PFS_T1OUT_PIN) == P2PFS_ALT_HIGH);
    st_d.t1ck = !cfg_all[P2PFS_T1CK_PIN*P2PFS_FLD_W + 1]
                & st_q.sync2[P2PFS_T1CK_PIN];
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_q        <= '0;
      st_q.cfg_lo <= P2PFS_CFG_RST;
      st_q.cfg_hi <= P2PFS_CFG_RST;
      st_q.rx     <= P2PFS_RX_IDLE;
      // The receive line fills at its idle level, so no false start bit follows reset.
      st_q.sync1[P2PFS_RX_PIN] <= P2PFS_RX_IDLE;
      st_q.sync2[P2PFS_RX_PIN] <= P2PFS_RX_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------------------
  for (genvar g = 0; g < P2PFS_PINS; g++) begin : g_pin
    p2pfs_pin_cell #(
      .DRIVE01 (P2PFS_DRIVE01_MASK[g]),
      .DRIVE11 (P2PFS_DRIVE11_MASK[g])
    ) u_cell (
      .clk_in      (clk_in),
      .sys_rst_in  (sys_rst_in),
      .code_in     (p2pfs_code_of(cfg_all, g)),
      .latch_in    (port_latch_in[g]),
      .alt_in      (alt_vec[g]),
      .pin_out_out (pin_out_out[g]),
      .pin_oe_out  (pin_oe_out[g])
    );
  end

  assign reg_rdata_out            = st_q.rdata;
  assign uart_rx_out              = st_q.rx;
  assign si_out                   = st_q.si;
  assign timer_one_ext_clock_out  = st_q.t1ck;
  assign analog_channel_seven_out = st_q.ach7;
  assign analog_channel_four_out  = st_q.ach4;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  property p_push_pull;
    (st_q.cfg_lo[3:2] == P2PFS_PUSH_PULL) ##1 (st_q.cfg_lo[3:2] == P2PFS_PUSH_PULL)
      |-> pin_oe_out[1] && (pin_out_out[1] == $past(port_latch_in[1]));
  endproperty
  a_push_pull: assert property (p_push_pull)
    else $error("Push-pull pin does not follow its data latch.");

  property p_unused_code;
    (st_q.cfg_hi[7:6] == P2PFS_ALT_LOW) |=> !pin_oe_out[P2PFS_TX_PIN];
  endproperty
  a_unused_code: assert property (p_unused_code)
    else $error("Unused code turned a pin driver on.");

  property p_rx_route;
    ((st_q.cfg_hi[5:4] == P2PFS_INPUT) || (st_q.cfg_hi[5:4] == P2PFS_ALT_HIGH))
      |=> (uart_rx_out == $past(st_q.sync2[P2PFS_RX_PIN])) && !pin_oe_out[P2PFS_RX_PIN];
  endproperty
  a_rx_route: assert property (p_rx_route)
    else $error("Receive pin is not routed to the receiver.");

  property p_sck_drive;
    (st_q.cfg_hi[3:2] == P2PFS_ALT_HIGH)
      |=> pin_oe_out[P2PFS_SCK_PIN] && (pin_out_out[P2PFS_SCK_PIN] == $past(sck_in));
  endproperty
  a_sck_drive: assert property (p_sck_drive)
    else $error("Serial clock is not driven on its pin.");

  property p_so_drive;
    (st_q.cfg_hi[1:0] == P2PFS_ALT_HIGH)
      |=> pin_oe_out[P2PFS_SO_PIN] && (pin_out_out[P2PFS_SO_PIN] == $past(so_in));
  endproperty
  a_so_drive: assert property (p_so_drive)
    else $error("Serial data is not driven on its pin.");

  property p_si_route;
    (st_q.cfg_lo[7:6] == P2PFS_INPUT) ##1 (st_q.cfg_lo[7:6] == P2PFS_INPUT)
      |-> (si_out == $past(st_q.sync2[P2PFS_SI_PIN])) && !pin_oe_out[P2PFS_SI_PIN];
  endproperty
  a_si_route: assert property (p_si_route)
    else $error("Serial input does not follow its pin.");

  property p_analog_seven;
    (st_q.cfg_lo[7:6] == P2PFS_ALT_HIGH) |=> analog_channel_seven_out
      && !pin_oe_out[P2PFS_SI_PIN] && !si_out;
  endproperty
  a_analog_seven: assert property (p_analog_seven)
    else $error("Analog channel seven not selected.");

  property p_t1out_drive;
    (st_q.cfg_lo[5:4] == P2PFS_ALT_LOW) |=> pin_oe_out[P2PFS_T1OUT_PIN]
      && (pin_out_out[P2PFS_T1OUT_PIN] == $past(timer_one_output_in));
  endproperty
  a_t1out_drive: assert property (p_t1out_drive)
    else $error("Timer output is not driven on its pin.");

  property p_analog_four;
    (analog_channel_four_out != $past(st_q.cfg_lo[5:4] == P2PFS_ALT_HIGH)) |-> $past(sys_rst_in);
  endproperty
  a_analog_four: assert property (p_analog_four)
    else $error("Analog channel four select disagrees with its field.");

  property p_t1ck_route;
    (st_q.cfg_lo[1] == 1'b0) |=> (timer_one_ext_clock_out == $past(st_q.sync2[P2PFS_T1CK_PIN]));
  endproperty
  a_t1ck_route: assert property (p_t1ck_route)
    else $error("Timer clock input does not follow its pin.");

  property p_pwm_drive;
    (st_q.cfg_lo[1:0] == P2PFS_ALT_HIGH) |=> pin_oe_out[P2PFS_T1CK_PIN]
      && (pin_out_out[P2PFS_T1CK_PIN] == $past(timebase_pwm_out_in)) && !timer_one_ext_clock_out;
  endproperty
  a_pwm_drive: assert property (p_pwm_drive)
    else $error("Timebase PWM is not driven on its pin.");

  property p_tx_drive;
    (st_q.cfg_hi[7:6] == P2PFS_ALT_HIGH)
      |=> pin_oe_out[P2PFS_TX_PIN] && (pin_out_out[P2PFS_TX_PIN] == $past(uart_tx_in));
  endproperty
  a_tx_drive: assert property (p_tx_drive)
    else $error("Transmit output is not driven on its pin.");

  property p_reset_state;
    @(posedge clk_in) disable iff (1'b0)
      sys_rst_in |=> (st_q.cfg_lo == P2PFS_CFG_RST) && (st_q.cfg_hi == P2PFS_CFG_RST)
        && (pin_oe_out == 8'h00) && (reg_rdata_out == P2PFS_RD_IDLE) && uart_rx_out;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("Configuration not cleared by reset.");

  property p_reg_write;
    (reg_wr_in && (reg_addr_in == P2PFS_HIGH_OFS)) ##1 (reg_rd_in && !reg_wr_in
      && (reg_addr_in == P2PFS_HIGH_OFS)) |=> (reg_rdata_out == $past(reg_wdata_in, 2));
  endproperty
  a_reg_write: assert property (p_reg_write)
    else $error("Read back differs from the value written.");

  property p_reg_write_low;
    (reg_wr_in && (reg_addr_in == P2PFS_LOW_OFS)) ##1 (reg_rd_in && !reg_wr_in
      && (reg_addr_in == P2PFS_LOW_OFS)) |=> (reg_rdata_out == $past(reg_wdata_in, 2));
  endproperty
  a_reg_write_low: assert property (p_reg_write_low)
    else $error("Read back of the low register differs from the value written.");

  property p_read_idle;
    (reg_rd_in && (reg_addr_in != P2PFS_LOW_OFS) && (reg_addr_in != P2PFS_HIGH_OFS))
      |=> (reg_rdata_out == P2PFS_RD_IDLE);
  endproperty
  a_read_idle: assert property (p_read_idle)
    else $error("Unmapped read did not return the idle value.");

  property p_rdata_hold;
    !reg_rd_in |=> $stable(reg_rdata_out);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("Read data changed without a read.");

  property p_rx_idle;
    ((st_q.cfg_hi[5:4] == P2PFS_ALT_LOW) || (st_q.cfg_hi[5:4] == P2PFS_PUSH_PULL))
      |=> uart_rx_out;
  endproperty
  a_rx_idle: assert property (p_rx_idle)
    else $error("Receiver not held idle while its pin is not routed.");

  property p_si_off;
    (st_q.cfg_lo[7:6] != P2PFS_INPUT) |=> !si_out;
  endproperty
  a_si_off: assert property (p_si_off)
    else $error("Serial input follows a pin that is not in input mode.");

  property p_analog_seven_off;
    (st_q.cfg_lo[7:6] != P2PFS_ALT_HIGH) |=> !analog_channel_seven_out;
  endproperty
  a_analog_seven_off: assert property (p_analog_seven_off)
    else $error("Analog channel seven selected without its code.");

  property p_unused_pin_one;
    (st_q.cfg_lo[3:2] == P2PFS_ALT_LOW) |=> !pin_oe_out[1];
  endproperty
  a_unused_pin_one: assert property (p_unused_pin_one)
    else $error("Unused code turned the pin one driver on.");

  property p_released_low;
    (pin_out_out & ~pin_oe_out) == 8'h00;
  endproperty
  a_released_low: assert property (p_released_low)
    else $error("A released pin carries a nonzero output value.");

  c_push_pull: cover property (st_q.cfg_lo[3:2] == P2PFS_PUSH_PULL ##1 pin_oe_out[1]);
  c_tx_alt:    cover property (st_q.cfg_hi[7:6] == P2PFS_ALT_HIGH ##1 pin_oe_out[7]);
  c_analog:    cover property (analog_channel_seven_out && analog_channel_four_out);
  c_readback:  cover property (reg_rd_in && (reg_addr_in == P2PFS_LOW_OFS) ##1 reg_rdata_out != 8'h00);
  c_unused:    cover property (st_q.cfg_hi[7:6] == P2PFS_ALT_LOW ##1 !pin_oe_out[7]);

endmodule : p2pfs_top

//--- dv/p2pfs_pad_model.sv
`timescale 1ns/10ps
module p2pfs_pad_model (
  input  wire logic [7:0] pin_out_in,
  input  wire logic [7:0] pin_oe_in,
  input  wire logic [7:0] ext_level_in,
  output logic      [7:0] pad_level_out
);
  // ---------------------------------------------------------------------------
  // Pad levels
  // ---------------------------------------------------------------------------
  // A driven pin shows the device driver; a released pin shows the outside level.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad_level_out[i] = pin_oe_in[i] ? pin_out_in[i] : ext_level_in[i];
    end
  end
endmodule : p2pfs_pad_model

//--- dv/p2pfs_tb_top.sv
`timescale 1ns/10ps
module p2pfs_tb_top;
  import p2pfs_pkg::*;
  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
    logic [7:0] latch;
    logic [4:0] per;
    logic [7:0] ext;
    logic [7:0] oe;
    logic [7:0] out;
    logic [4:0] res;
  } p2pfs_row_t;
  // Peripheral drive order is {tx, sck, so, timer out, pwm}; results {rx, si, ck, an7, an4}.
  localparam p2pfs_row_t ROWS [8] = '{
    '{8'h00, 8'h00, 8'hff, 5'h1f, 8'h49, 8'h00, 8'h00, 5'h1c},
    '{8'h00, 8'h00, 8'hff, 5'h1f, 8'hb6, 8'h00, 8'h00, 5'h00},
    '{8'haa, 8'haa, 8'h5a, 5'h1f, 8'hff, 8'hff, 8'h5a, 5'h10},
    '{8'h55, 8'h55, 8'hff, 5'h1f, 8'h01, 8'h04, 8'h04, 5'h14},
    '{8'h55, 8'h55, 8'hff, 5'h1d, 8'h00, 8'h04, 8'h00, 5'h10},
    '{8'hff, 8'hff, 8'h00, 5'h1f, 8'h00, 8'hb1, 8'hb1, 5'h03},
    '{8'hff, 8'hff, 8'h00, 5'h00, 8'h40, 8'hb1, 8'h00, 5'h13},
    '{8'h2d, 8'hb4, 8'h84, 5'h1f, 8'h49, 8'h84, 8'h84, 5'h1c}
  };
  logic       clk_in;
  logic       sys_rst_in;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] latch;
  logic [7:0] ext;
  logic [7:0] pad;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic [4:0] per;
  logic [4:0] res;
  int         n_fail;
  int         cmp_count;

  p2pfs_top dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata),
    .port_latch_in(latch), .pin_in(pad), .pin_out_out(pin_out), .pin_oe_out(pin_oe),
    .uart_tx_in(per[4]), .sck_in(per[3]), .so_in(per[2]), .timer_one_output_in(per[1]),
    .timebase_pwm_out_in(per[0]), .uart_rx_out(res[4]), .si_out(res[3]),
    .timer_one_ext_clock_out(res[2]), .analog_channel_seven_out(res[1]),
    .analog_channel_four_out(res[0])
  );
  p2pfs_pad_model pads (
    .pin_out_in(pin_out), .pin_oe_in(pin_oe), .ext_level_in(ext), .pad_level_out(pad)
  );

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0d ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk_in);
    reg_addr = addr;
    reg_wdata = data;
    reg_wr = 1'b1;
    @(negedge clk_in);
    reg_wr = 1'b0;
  endtask : reg_write

  task automatic reg_check(input logic [7:0] addr, input logic [7:0] exp);
    @(negedge clk_in);
    reg_addr = addr;
    reg_rd = 1'b1;
    @(negedge clk_in);
    reg_rd = 1'b0;
    check(reg_rdata, exp);
  endtask : reg_check

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  // ---------------------------------------------------------------------------
  // Clock, watchdog and sequence
  // ---------------------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // The whole sequence needs about 130 cycles; 5000 leaves ample margin.
  initial begin : watchdog
    #(5000 * 10);
    n_fail++;
    $display("Watchdog expired");
    end_of_test();
  end

  initial begin : main
    n_fail = 0;
    cmp_count = 0;
    sys_rst_in = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    latch = 8'hff;
    per = 5'h1f;
    ext = 8'hff;
    repeat (10) @(negedge clk_in);
    sys_rst_in = 1'b0;
    check(pin_oe, 8'h00);
    check({3'h0, res}, 8'h10);
    // The receiver must not see a false start bit while the synchronisers fill.
    repeat (3) begin
      @(negedge clk_in);
      check({7'h00, res[4]}, 8'h01);
    end
    reg_check(P2PFS_LOW_OFS, 8'h00);
    reg_check(P2PFS_HIGH_OFS, 8'h00);
    $display("Reset test done");
    foreach (ROWS[i]) begin
      reg_write(P2PFS_LOW_OFS, ROWS[i].low);
      reg_write(P2PFS_HIGH_OFS, ROWS[i].high);
      latch = ROWS[i].latch;
      per = ROWS[i].per;
      ext = ROWS[i].ext;
      repeat (4) @(negedge clk_in);
      check(pin_oe, ROWS[i].oe);
      check(pin_out, ROWS[i].out);
      check({3'h0, res}, {3'h0, ROWS[i].res});
      reg_check(P2PFS_LOW_OFS, ROWS[i].low);
      reg_check(P2PFS_HIGH_OFS, ROWS[i].high);
      $display("Row test %0d done", i);
    end
    // An unmapped write must leave both registers and the pins alone.
    reg_write(8'hee, 8'hff);
    reg_check(8'hee, 8'h00);
    reg_check(P2PFS_LOW_OFS, 8'h2d);
    reg_check(P2PFS_HIGH_OFS, 8'hb4);
    check(pin_oe, 8'h84);
    $display("Unmapped access test done");
    // A read straight after a write returns the new value.
    @(negedge clk_in);
    reg_addr = P2PFS_HIGH_OFS;
    reg_wdata = 8'hc3;
    reg_wr = 1'b1;
    @(negedge clk_in);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(negedge clk_in);
    check(reg_rdata, 8'hc3);
    reg_rd = 1'b0;
    reg_addr = P2PFS_LOW_OFS;
    reg_wdata = 8'h3c;
    reg_wr = 1'b1;
    @(negedge clk_in);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(negedge clk_in);
    reg_rd = 1'b0;
    check(reg_rdata, 8'h3c);
    check(pin_oe, 8'h90);
    check(pin_out, 8'h90);
    check({7'h00, res[0]}, 8'h01);
    $display("Back-to-back access test done");
    // A reset in mid-run returns every pin to input mode.
    sys_rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    sys_rst_in = 1'b0;
    check(pin_oe, 8'h00);
    check(pin_out, 8'h00);
    check({3'h0, res}, 8'h10);
    reg_check(P2PFS_LOW_OFS, 8'h00);
    reg_check(P2PFS_HIGH_OFS, 8'h00);
    $display("Mid-run reset test done");
    end_of_test();
  end
endmodule : p2pfs_tb_top

//--- shared/p2pfs_pkg.sv
package p2pfs_pkg;

  // ---------------------------------------------------------------------------
  // Register map and reset values
  // ---------------------------------------------------------------------------
  localparam int unsigned P2PFS_PINS     = 8;
  localparam logic [7:0]  P2PFS_LOW_OFS  = 8'hed;
  localparam logic [7:0]  P2PFS_HIGH_OFS = 8'hec;
  localparam logic [7:0]  P2PFS_CFG_RST  = 8'h00;
  localparam logic [7:0]  P2PFS_RD_IDLE  = 8'h00;

  // ---------------------------------------------------------------------------
  // Field layout and function codes
  // ---------------------------------------------------------------------------
  localparam int unsigned P2PFS_FLD_W     = 2;
  localparam logic [1:0]  P2PFS_INPUT     = 2'h0;
  localparam logic [1:0]  P2PFS_ALT_LOW   = 2'h1;
  localparam logic [1:0]  P2PFS_PUSH_PULL = 2'h2;
  localparam logic [1:0]  P2PFS_ALT_HIGH  = 2'h3;

  // Pins on which code 01 or code 11 turns on the driver with a peripheral output.
  localparam logic [7:0]  P2PFS_DRIVE01_MASK = 8'h04;
  localparam logic [7:0]  P2PFS_DRIVE11_MASK = 8'hb1;

  // ---------------------------------------------------------------------------
  // Pin positions of the alternate functions
  // ---------------------------------------------------------------------------
  localparam int unsigned P2PFS_TX_PIN    = 7;
  localparam int unsigned P2PFS_RX_PIN    = 6;
  localparam int unsigned P2PFS_SCK_PIN   = 5;
  localparam int unsigned P2PFS_SO_PIN    = 4;
  localparam int unsigned P2PFS_SI_PIN    = 3;
  localparam int unsigned P2PFS_T1OUT_PIN = 2;
  localparam int unsigned P2PFS_T1CK_PIN  = 0;

  // Receiver line level while its pin is not routed to it.
  localparam logic        P2PFS_RX_IDLE   = 1'b1;

  // Picks the 2-bit field of one pin out of {high, low} configuration.
  function automatic logic [1:0] p2pfs_code_of(input logic [15:0] cfg, input int unsigned pin);
    p2pfs_code_of = cfg[pin*P2PFS_FLD_W +: P2PFS_FLD_W];
  endfunction : p2pfs_code_of

endpackage : p2pfs_pkg
